// file: hw/scss_map.svh
// register offsets, field positions and reset values of the clock source select block
`ifndef SCSS_MAP_SVH
`define SCSS_MAP_SVH

`define SCSS_STATUS_OFFSET      12'h00c
`define SCSS_SELECT_OFFSET      12'h010

`define SCSS_SYS_FIELD_MSB      2
`define SCSS_SYS_FIELD_LSB      0
`define SCSS_TICK_FIELD_MSB     5
`define SCSS_TICK_FIELD_LSB     3
`define SCSS_BOOT_FIELD_MSB     26
`define SCSS_BOOT_FIELD_LSB     24

`define SCSS_STAT_XTAL_BIT      0
`define SCSS_STAT_PLL_BIT       2
`define SCSS_STAT_LIRC_BIT      3
`define SCSS_STAT_HIRC_BIT      4
`define SCSS_STAT_FAIL_BIT      7

`define SCSS_SYS_RESET          3'h7
`define SCSS_TICK_RESET         3'h7
`define SCSS_ZERO_WORD          32'h0000_0000

`endif

// file: hw/scss_pkg.sv
// types and shared decode helpers of the clock source select block
package scss_pkg;

    typedef enum logic [2:0] {
        SYS_XTAL = 3'h0,
        SYS_PLL  = 3'h2,
        SYS_LIRC = 3'h3,
        SYS_HIRC = 3'h7
    } scss_sys_src_t;

    typedef enum logic [2:0] {
        TICK_XTAL      = 3'h0,
        TICK_XTAL_DIV2 = 3'h2,
        TICK_SYS_DIV2  = 3'h3,
        TICK_HIRC_DIV2 = 3'h7
    } scss_tick_src_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'h1,
        SW_WAIT = 2'h2
    } scss_sw_state_t;

    function automatic logic scss_sys_valid(input logic [2:0] code);
        scss_sys_valid = (code == SYS_XTAL) || (code == SYS_PLL) ||
                         (code == SYS_LIRC) || (code == SYS_HIRC);
    endfunction : scss_sys_valid

    function automatic logic scss_tick_valid(input logic [2:0] code);
        scss_tick_valid = (code == TICK_XTAL) || (code == TICK_XTAL_DIV2) ||
                          (code == TICK_SYS_DIV2) || (code == TICK_HIRC_DIV2);
    endfunction : scss_tick_valid

endpackage : scss_pkg

// file: hw/scss_switch_if.sv
// carrier between the register front end and the clock switch sequencer
`timescale 1ns/10ps
interface scss_switch_if;
    logic [2:0] requested;
    logic       bootLoad;
    logic [2:0] bootCode;
    logic       xtalStable;
    logic       pllStable;
    logic       lircStable;
    logic       hircStable;
    logic [2:0] running;
    logic       switchFail;

    modport ctrl (
        output requested,
        output bootLoad,
        output bootCode,
        output xtalStable,
        output pllStable,
        output lircStable,
        output hircStable,
        input  running,
        input  switchFail
    );

    modport sw (
        input  requested,
        input  bootLoad,
        input  bootCode,
        input  xtalStable,
        input  pllStable,
        input  lircStable,
        input  hircStable,
        output running,
        output switchFail
    );
endinterface : scss_switch_if

// file: hw/scss_clock_switch.sv
// sequencer that holds the running system clock source until the new one is stable
`timescale 1ns/10ps
`include "scss_map.svh"
module scss_clock_switch (
    input  wire logic   clk,
    input  wire logic   rstN,
    scss_switch_if.sw   link
);
    scss_pkg::scss_sw_state_t state_q;
    scss_pkg::scss_sw_state_t state_d;
    logic [2:0]               running_q;
    logic [2:0]               running_d;
    logic                     fail_q;
    logic                     targetStable;

    always_comb begin
        case (link.requested)
            scss_pkg::SYS_XTAL: targetStable = link.xtalStable;
            scss_pkg::SYS_PLL:  targetStable = link.pllStable;
            scss_pkg::SYS_LIRC: targetStable = link.lircStable;
            scss_pkg::SYS_HIRC: targetStable = link.hircStable;
            default:            targetStable = 1'b0;
        endcase
    end

    always_comb begin
        state_d   = state_q;
        running_d = running_q;
        if (link.bootLoad) begin
            running_d = link.bootCode;
            state_d   = scss_pkg::SW_IDLE;
        end else begin
            case (state_q)
                scss_pkg::SW_IDLE: begin
                    if (link.requested != running_q)
                        state_d = scss_pkg::SW_WAIT;
                end
                scss_pkg::SW_WAIT: begin
                    // old source is assumed still enabled while we wait
                    if (link.requested == running_q) begin
                        state_d = scss_pkg::SW_IDLE;
                    end else if (targetStable && scss_pkg::scss_sys_valid(link.requested)) begin
                        running_d = link.requested;
                        state_d   = scss_pkg::SW_IDLE;
                    end
                end
                default: state_d = scss_pkg::SW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN)
            state_q <= scss_pkg::SW_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN)
            running_q <= `SCSS_SYS_RESET;
        else
            running_q <= running_d;
    end

    // flag reflects mismatch in the same cycle the running source moves
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN)
            fail_q <= 1'b0;
        else
            fail_q <= (running_d != (link.bootLoad ? link.bootCode : link.requested));
    end

    assign link.running    = running_q;
    assign link.switchFail = fail_q;
endmodule : scss_clock_switch

// file: hw/scss_clock_source_select.sv
// APB front end and selection logic for the system and tick clock sources
//
// Contract
// - The system clock field at bits 2..0 selects crystal (000), PLL (010), 10 kHz (011) or 22.1184 MHz (111).
// - The tick clock field at bits 5..3 selects crystal, crystal/2, system clock/2 or 22.1184 MHz/2.
// - The tick timer uses the tick clock field only when the tick control clock-source bit is zero.
// - Every reset reloads the system clock field from the flash boot oscillator configuration bits 26..24; code loads 111 for a reserved code.
// - Both source fields change only while the write-protection unlock is active.
// - The select register is a 32-bit word at 0x10 resetting to 0x0000_003X with bits 31..6 reserved.
// - The system clock stays on the old source until the new is stable, and the fail flag shows any mismatch.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "scss_map.svh"
module scss_clock_source_select #(
    parameter int ADDR_WIDTH = 12
) (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // system context
    input  wire logic                  writeProtectOpen,
    input  wire logic [31:0]           userConfigWord0,
    input  wire logic                  tickControlClkSrc,
    input  wire logic                  xtalStable,
    input  wire logic                  pllStable,
    input  wire logic                  lircStable,
    input  wire logic                  hircStable,
    // clock tree controls
    output logic      [2:0]            sysClkSel,
    output logic      [2:0]            tickClkSel,
    output logic                       tickOnSysClk,
    output logic                       clockSwitchFail
);

    if (ADDR_WIDTH < 5 || ADDR_WIDTH > 32) begin : g_bad_width
        $error("ADDR_WIDTH must lie between 5 and 32");
    end

    localparam logic [ADDR_WIDTH-1:0] SELECT_ADDR = ADDR_WIDTH'(`SCSS_SELECT_OFFSET);
    localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR = ADDR_WIDTH'(`SCSS_STATUS_OFFSET);

    // reset release synchroniser
    logic        rstSync1_q;
    logic        rstSync2_q;
    logic        rstN;

    // apb pipeline
    logic        setupPhase;
    logic        writeStrobe;
    logic        addrSelect;
    logic        addrStatus;
    logic [31:0] readWord;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    // select register fields
    logic [2:0]  sysField_q;
    logic [2:0]  tickField_q;
    logic [2:0]  bootCode;
    logic        bootPending_q;

    // registered outputs
    logic [2:0]  tickSel_q;
    logic        tickOnSys_q;
    logic [2:0]  sysSel_q;
    logic        switchFail_q;

    scss_switch_if swLink ();

    // ------------------------------------------------------------ reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end

    assign rstN = rstSync2_q;

    // ------------------------------------------------------------ decode
    function automatic logic hitsAddr(input logic [ADDR_WIDTH-1:0] addr,
                                      input logic [ADDR_WIDTH-1:0] target);
        hitsAddr = (addr == target);
    endfunction : hitsAddr

    assign addrSelect  = hitsAddr(paddr, SELECT_ADDR);
    assign addrStatus  = hitsAddr(paddr, STATUS_ADDR);
    assign setupPhase  = psel && !penable;
    assign writeStrobe = psel && penable && pready_q && pwrite;

    always_comb begin
        readWord = `SCSS_ZERO_WORD;
        if (addrSelect) begin
            // reserved upper bits read as zero
            readWord[`SCSS_SYS_FIELD_MSB:`SCSS_SYS_FIELD_LSB]   = sysField_q;
            readWord[`SCSS_TICK_FIELD_MSB:`SCSS_TICK_FIELD_LSB] = tickField_q;
        end else if (addrStatus) begin
            readWord[`SCSS_STAT_XTAL_BIT] = xtalStable;
            readWord[`SCSS_STAT_PLL_BIT]  = pllStable;
            readWord[`SCSS_STAT_LIRC_BIT] = lircStable;
            readWord[`SCSS_STAT_HIRC_BIT] = hircStable;
            readWord[`SCSS_STAT_FAIL_BIT] = swLink.switchFail;
        end
    end

    // ------------------------------------------------------------ apb answer
    // data captured in setup so access phase always completes with no wait
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
            pready_q <= 1'b0;
        else
            pready_q <= setupPhase;
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
            pslverr_q <= 1'b0;
        else
            pslverr_q <= setupPhase && !(addrSelect || addrStatus);
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
            prdata_q <= `SCSS_ZERO_WORD;
        else if (setupPhase && !pwrite)
            prdata_q <= readWord;
        else if (!psel)
            prdata_q <= `SCSS_ZERO_WORD;
    end

    // ------------------------------------------------------------ boot load
    // strap is taken one cycle after reset release, never inside the reset branch
    assign bootCode = scss_pkg::scss_sys_valid(userConfigWord0[`SCSS_BOOT_FIELD_MSB:`SCSS_BOOT_FIELD_LSB])
                    ? userConfigWord0[`SCSS_BOOT_FIELD_MSB:`SCSS_BOOT_FIELD_LSB]
                    : `SCSS_SYS_RESET;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
            bootPending_q <= 1'b1;
        else
            bootPending_q <= 1'b0;
    end

    // ------------------------------------------------------------ select register
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            sysField_q <= `SCSS_SYS_RESET;
        end else if (bootPending_q) begin
            sysField_q <= bootCode;
        end else if (writeStrobe && addrSelect && writeProtectOpen
                     && scss_pkg::scss_sys_valid(pwdata[`SCSS_SYS_FIELD_MSB:`SCSS_SYS_FIELD_LSB])) begin
            sysField_q <= pwdata[`SCSS_SYS_FIELD_MSB:`SCSS_SYS_FIELD_LSB];
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            tickField_q <= `SCSS_TICK_RESET;
        end else if (writeStrobe && addrSelect && writeProtectOpen
                     && scss_pkg::scss_tick_valid(pwdata[`SCSS_TICK_FIELD_MSB:`SCSS_TICK_FIELD_LSB])) begin
            tickField_q <= pwdata[`SCSS_TICK_FIELD_MSB:`SCSS_TICK_FIELD_LSB];
        end
    end

    // ------------------------------------------------------------ switch sequencer
    assign swLink.requested  = sysField_q;
    assign swLink.bootLoad   = bootPending_q;
    assign swLink.bootCode   = bootCode;
    assign swLink.xtalStable = xtalStable;
    assign swLink.pllStable  = pllStable;
    assign swLink.lircStable = lircStable;
    assign swLink.hircStable = hircStable;

    scss_clock_switch u_switch (
        .clk  (mclk),
        .rstN (rstN),
        .link (swLink.sw)
    );

    // ------------------------------------------------------------ output stage
    // one extra flop keeps every top output registered at the cost of a cycle
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
            sysSel_q <= `SCSS_SYS_RESET;
        else
            sysSel_q <= swLink.running;
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN)
            switchFail_q <= 1'b0;
        else
            switchFail_q <= swLink.switchFail;
    end

    // tick source ratio against the system clock is software's burden
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            tickOnSys_q <= 1'b0;
            tickSel_q   <= `SCSS_TICK_RESET;
        end else begin
            tickOnSys_q <= tickControlClkSrc;
            tickSel_q   <= tickField_q;
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign sysClkSel       = sysSel_q;
    assign tickClkSel      = tickSel_q;
    assign tickOnSysClk    = tickOnSys_q;
    assign clockSwitchFail = switchFail_q;

endmodule : scss_clock_source_select

// file: test/scss_monitor.sv
// concurrent checks on the ports of the clock source select block
`timescale 1ns/10ps
module scss_monitor #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic                  mclk,
    input wire logic                  reset_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  writeProtectOpen,
    input wire logic                  tickControlClkSrc,
    input wire logic                  pllStable,
    input wire logic [2:0]            sysClkSel,
    input wire logic [2:0]            tickClkSel,
    input wire logic                  tickOnSysClk,
    input wire logic                  clockSwitchFail
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire logic selWr = psel && penable && pready && pwrite && paddr == 12'h010;

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_error_a: assert property (psel && !penable && paddr != 12'h010 && paddr != 12'h00c
        |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    reserved_zero_a: assert property (pready && !pwrite && paddr == 12'h010 |-> prdata[31:6] == 26'h0)
        else $error("reserved bits not zero");
    locked_tick_a: assert property (selWr && !writeProtectOpen |=> $stable(tickClkSel) [*3])
        else $error("locked write changed tick field");
    tick_reserved_a: assert property (selWr && !(pwdata[5:3] inside {3'h0, 3'h2, 3'h3, 3'h7})
        |=> $stable(tickClkSel) [*3]) else $error("reserved tick code taken");
    sys_legal_a: assert property (sysClkSel inside {3'h0, 3'h2, 3'h3, 3'h7})
        else $error("running source undefined");
    pll_stable_a: assert property ($rose(sysClkSel == 3'h2) |-> $past(pllStable, 2))
        else $error("switched to unstable pll");
    fail_raise_a: assert property (selWr && writeProtectOpen && pwdata[2:0] == 3'h2 && !pllStable
        && sysClkSel != 3'h2 |-> ##[1:3] clockSwitchFail) else $error("fail flag not raised");
    tick_source_a: assert property ($rose(tickControlClkSrc) |-> ##[1:3] tickOnSysClk)
        else $error("tick not moved to system clock");
endmodule : scss_monitor

// file: test/scss_osc_model.sv
// behavioural sources: stable flag follows enable after a start-up delay
`timescale 1ns/10ps
module scss_osc_model #(
    parameter int START = 16
) (
    input wire logic       mclk,
    input wire logic [3:0] oscEn,
    output logic     [3:0] oscStable
);
    int cnt [4];
    // disabling drops the flag at once, so a switch can be made to wait
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= oscEn[i] ? (cnt[i] < START ? cnt[i] + 1 : START) : 0;
            oscStable[i] <= oscEn[i] && cnt[i] >= START - 1;
        end
    end
endmodule : scss_osc_model

// file: test/test_scss_clock_source_select.sv
// self-checking bench for the clock source select block
`timescale 1ns/10ps
module test_scss_clock_source_select;
    logic        mclk = 1'h0;
    logic        reset_n = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, userConfigWord0 = 32'h0;
    logic        pready, pslverr, err;
    logic        writeProtectOpen = 1'h0;
    logic        tickControlClkSrc = 1'h0;
    logic [3:0]  oscEn = 4'hf;
    logic [3:0]  oscStable;
    logic [2:0]  sysClkSel, tickClkSel;
    logic        tickOnSysClk, clockSwitchFail;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [2:0]  sysCodes [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
    logic [2:0]  tickCodes [4] = '{3'h2, 3'h3, 3'h7, 3'h0};

    scss_clock_source_select i_dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .writeProtectOpen, .userConfigWord0, .tickControlClkSrc,
        .xtalStable(oscStable[0]), .pllStable(oscStable[1]), .lircStable(oscStable[2]),
        .hircStable(oscStable[3]), .sysClkSel, .tickClkSel, .tickOnSysClk, .clockSwitchFail);
    scss_osc_model i_osc (.mclk, .oscEn, .oscStable);

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // request held until ready is sampled high at a rising edge; the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask : apb

    task automatic do_reset(input logic [2:0] boot);
        reset_n <= 1'h0;
        userConfigWord0 <= {5'h1f, boot, 24'habcdef};
        repeat (2) @(posedge mclk);
        reset_n <= 1'h1;
        repeat (4) @(posedge mclk);
    endtask : do_reset

    // switch raises its flag two edges after the write, then waits for the source
    task automatic settle();
        int n;
        n = 0;
        repeat (2) @(posedge mclk);
        while (clockSwitchFail !== 1'h0 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
    endtask : settle

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        do_reset(3'h7);
        apb(1'h0, 12'h010, 32'h0);
        chk("select after boot 7", rd, 32'h3f);
        do_reset(3'h0);
        apb(1'h0, 12'h010, 32'h0);
        chk("select after boot 0", rd, 32'h38);
        chk("running after boot", 32'(sysClkSel), 32'h0);
        apb(1'h1, 12'h010, 32'h12);
        settle();
        apb(1'h0, 12'h010, 32'h0);
        chk("locked write", rd, 32'h38);
        writeProtectOpen <= 1'h1;
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, 12'h010, {26'h3ffffff, tickCodes[i], sysCodes[i]});
            settle();
            apb(1'h0, 12'h010, 32'h0);
            chk("select readback", rd, {26'h0, tickCodes[i], sysCodes[i]});
            chk("running source", 32'(sysClkSel), 32'(sysCodes[i]));
            chk("tick source", 32'(tickClkSel), 32'(tickCodes[i]));
        end
        apb(1'h1, 12'h010, 32'h21);
        settle();
        apb(1'h0, 12'h010, 32'h0);
        chk("both reserved", rd, 32'h07);
        apb(1'h1, 12'h010, 32'h15);
        settle();
        apb(1'h0, 12'h010, 32'h0);
        chk("sys reserved only", rd, 32'h17);
        oscEn[1] <= 1'h0;
        repeat (3) @(posedge mclk);
        // both sources enabled before the switch; pll not yet stable
        oscEn[1] <= 1'h1;
        apb(1'h1, 12'h010, 32'h12);
        repeat (2) @(posedge mclk);
        chk("fail while waiting", 32'(clockSwitchFail), 32'h1);
        chk("old source held", 32'(sysClkSel), 32'h7);
        apb(1'h0, 12'h00c, 32'h0);
        chk("status fail bit", 32'(rd[7]), 32'h1);
        chk("status word", rd, 32'h99);
        settle();
        chk("switched to pll", 32'(sysClkSel), 32'h2);
        chk("fail cleared", 32'(clockSwitchFail), 32'h0);
        tickControlClkSrc <= 1'h1;
        repeat (3) @(posedge mclk);
        chk("tick on system clock", 32'(tickOnSysClk), 32'h1);
        tickControlClkSrc <= 1'h0;
        repeat (3) @(posedge mclk);
        chk("tick on field", 32'(tickOnSysClk), 32'h0);
        apb(1'h0, 12'h020, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        do_reset(3'h5);
        apb(1'h0, 12'h010, 32'h0);
        chk("select after bad boot", rd, 32'h3f);
        chk("running after bad boot", 32'(sysClkSel), 32'h7);
        tally_and_finish();
    end
endmodule : test_scss_clock_source_select

bind scss_clock_source_select scss_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) i_mon (.mclk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .writeProtectOpen, .tickControlClkSrc, .pllStable,
    .sysClkSel, .tickClkSel, .tickOnSysClk, .clockSwitchFail);
